// ### swe_pkg.sv
// Package for the sleep/wake event logic, plus the sticky flag vector that it instantiates.
// Assumes one clock, a synchronous active-high reset and inputs synchronous to that clock.
package swe_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int N_SRC = 9;
  localparam int STRAP_W = 3;

  // Wake source bit positions in the latch, status and mask words
  localparam int SRC_PWRBTN = 0;
  localparam int SRC_SMBALERT = 1;
  localparam int SRC_PCIE_WAKE = 2;
  localparam int SRC_WDT_PWRBTN = 3;
  localparam int SRC_GEN_WAKE = 4;
  localparam int SRC_PME = 5;
  localparam int SRC_RTC = 6;
  localparam int SRC_USB = 7;
  localparam int SRC_LAN = 8;

  // Control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_PME_EN = 0;
  localparam int CTRL_PME_CAP = 1;
  localparam int CTRL_RTC_EN = 2;
  localparam int CTRL_USB_EN = 3;
  localparam int CTRL_LAN_EN = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [N_SRC-1:0] MASK_RESET = 9'h000;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_LATCH = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h10;
  localparam int STATE_REQ_BIT = 2;

  typedef enum logic [1:0] {
    SWE_WORK = 2'b00,
    SWE_S3 = 2'b01,
    SWE_S4 = 2'b10,
    SWE_S5 = 2'b11
  } swe_state_e;

  // Suspend status pins, all low-active
  typedef struct packed {
    logic s3_n;
    logic s4_n;
    logic s5_n;
  } swe_sus_s;

  // Wake source pins as they arrive from the carrier
  typedef struct packed {
    logic pwrbtn_n;
    logic smbalert_n;
    logic pcie_wake_n;
    logic wdt_pwrbtn;
    logic gen_wake_n;
    logic pme_n;
    logic rtc_alarm;
    logic usb_wake;
    logic lan_wake;
  } swe_wake_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } swe_bus_s;
endpackage : swe_pkg

`timescale 1ns/1ns
module swe_sticky #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] q_out
);
  // A set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q_out <= '0;
    end else begin
      q_out <= (q_out & ~clr_in) | set_in;
    end
  end
endmodule : swe_sticky

// ### swe_wake_logic.sv
// Sleep state decode, wake source qualification, wake latches and register port.
// Assumes pins are already synchronous to clk_sys_in and the block sits on standby power.
// Functional notes
// - Track S3, S4, S5 sleep states; request resume when a permitted source asserts.
// - Power button, SMB alert, PCIe wake, watchdog button wake from S3-S5 always.
// - General wake input wakes from S3 only, without any enable.
// - PME wakes only if resume-on-PME or device wake capability is enabled.
// - RTC alarm wakes only when enabled, and only from S5.
// - USB activity wakes from S3/S4 when enabled; USB kept on standby in S3.
// - Network controller wake acts only when network wake is configured.
// - Names ending in _n are asserted low; all others asserted high.
// - Pinout type reported on straps, each grounded or left open.
`timescale 1ns/1ns
module swe_wake_logic #(
  // Pinout type code; a one bit is a strap tied to ground (arbitrary value)
  parameter logic [swe_pkg::STRAP_W-1:0] STRAP_TIED_GND = 3'h1
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire swe_pkg::swe_sus_s sus_in,
  input wire swe_pkg::swe_wake_s wake_in,
  input wire swe_pkg::swe_bus_s bus_in,
  output logic [swe_pkg::DATA_W-1:0] rdata_out,
  output logic wake_req_out,
  output logic irq_out,
  output logic usb_sby_pwr_out,
  output logic [swe_pkg::STRAP_W-1:0] capability_strap_out,
  output logic [swe_pkg::STRAP_W-1:0] capability_strap_oe_n_out
);
  import swe_pkg::*;

  swe_state_e state_q;
  swe_state_e state_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [N_SRC-1:0] mask_q;
  logic [N_SRC-1:0] act;
  logic [N_SRC-1:0] permit;
  logic [N_SRC-1:0] latch_set;
  logic [N_SRC-1:0] latch_clr;
  logic [N_SRC-1:0] latch_q;
  logic [N_SRC-1:0] status_set;
  logic [N_SRC-1:0] status_clr;
  logic [N_SRC-1:0] status_q;
  logic asleep;
  logic wr_status;

  // Low-active pins are inverted once here so everything below is active high
  always_comb begin
    act = '0;
    act[SRC_PWRBTN] = ~wake_in.pwrbtn_n;
    act[SRC_SMBALERT] = ~wake_in.smbalert_n;
    act[SRC_PCIE_WAKE] = ~wake_in.pcie_wake_n;
    act[SRC_WDT_PWRBTN] = wake_in.wdt_pwrbtn;
    act[SRC_GEN_WAKE] = ~wake_in.gen_wake_n;
    act[SRC_PME] = ~wake_in.pme_n;
    act[SRC_RTC] = wake_in.rtc_alarm;
    act[SRC_USB] = wake_in.usb_wake;
    act[SRC_LAN] = wake_in.lan_wake;
  end

  // Deepest asserted suspend signal wins; sequencing asserts S3 under S4 under S5
  always_comb begin
    if (!sus_in.s5_n) begin
      state_d = SWE_S5;
    end else if (!sus_in.s4_n) begin
      state_d = SWE_S4;
    end else if (!sus_in.s3_n) begin
      state_d = SWE_S3;
    end else begin
      state_d = SWE_WORK;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= SWE_WORK;
    end else begin
      state_q <= state_d;
    end
  end

  assign asleep = (state_q != SWE_WORK);

  // Which sources may wake in the present sleep state
  always_comb begin
    permit = '0;
    case (state_q)
      SWE_S3: begin
        permit[SRC_PWRBTN] = 1'b1;
        permit[SRC_SMBALERT] = 1'b1;
        permit[SRC_PCIE_WAKE] = 1'b1;
        permit[SRC_WDT_PWRBTN] = 1'b1;
        permit[SRC_GEN_WAKE] = 1'b1;
        permit[SRC_USB] = ctrl_q[CTRL_USB_EN];
      end
      SWE_S4: begin
        permit[SRC_PWRBTN] = 1'b1;
        permit[SRC_SMBALERT] = 1'b1;
        permit[SRC_PCIE_WAKE] = 1'b1;
        permit[SRC_WDT_PWRBTN] = 1'b1;
        permit[SRC_USB] = ctrl_q[CTRL_USB_EN];
      end
      SWE_S5: begin
        permit[SRC_PWRBTN] = 1'b1;
        permit[SRC_SMBALERT] = 1'b1;
        permit[SRC_PCIE_WAKE] = 1'b1;
        permit[SRC_WDT_PWRBTN] = 1'b1;
        permit[SRC_RTC] = ctrl_q[CTRL_RTC_EN];
      end
      default: begin
        permit = '0;
      end
    endcase
    // PME and network wake are not tied to one sleep state
    if (asleep) begin
      permit[SRC_PME] = ctrl_q[CTRL_PME_EN] | ctrl_q[CTRL_PME_CAP];
      permit[SRC_LAN] = ctrl_q[CTRL_LAN_EN];
    end
  end

  assign latch_set = act & permit;
  // Latches empty while working; sets only happen asleep, so the two never meet
  assign latch_clr = {N_SRC{~asleep}};

  swe_sticky #(
    .W(N_SRC)
  ) u_latch (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .set_in(latch_set),
    .clr_in(latch_clr),
    .q_out(latch_q)
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wake_req_out <= 1'b0;
    end else begin
      wake_req_out <= |latch_q;
    end
  end

  // Status records each newly latched source for software
  assign status_set = latch_set & ~latch_q;
  assign wr_status = bus_in.we && (bus_in.addr == ADDR_STATUS);
  assign status_clr = wr_status ? bus_in.wdata[N_SRC-1:0] : '0;

  swe_sticky #(
    .W(N_SRC)
  ) u_status (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .set_in(status_set),
    .clr_in(status_clr),
    .q_out(status_q)
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_q & mask_q);
    end
  end

  // USB must keep standby power through S3 so it can still signal a wake
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      usb_sby_pwr_out <= 1'b0;
    end else begin
      usb_sby_pwr_out <= (state_q == SWE_S3);
    end
  end

  // Open straps: an open one is never driven, a grounded one drives low forever
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      capability_strap_out <= '0;
      capability_strap_oe_n_out <= ~STRAP_TIED_GND;
    end else begin
      capability_strap_out <= '0;
      capability_strap_oe_n_out <= ~STRAP_TIED_GND;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end else if (bus_in.we) begin
      if (bus_in.addr == ADDR_CTRL) begin
        ctrl_q <= bus_in.wdata[CTRL_W-1:0];
      end
      if (bus_in.addr == ADDR_MASK) begin
        mask_q <= bus_in.wdata[N_SRC-1:0];
      end
    end
  end

  // Read data stands for exactly one cycle; unmapped addresses read zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (bus_in.re) begin
      case (bus_in.addr)
        ADDR_CTRL: rdata_out <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
        ADDR_MASK: rdata_out <= {{(DATA_W-N_SRC){1'b0}}, mask_q};
        ADDR_STATUS: rdata_out <= {{(DATA_W-N_SRC){1'b0}}, status_q};
        ADDR_LATCH: rdata_out <= {{(DATA_W-N_SRC){1'b0}}, latch_q};
        ADDR_STATE: rdata_out <= {{(DATA_W-STATE_REQ_BIT-1){1'b0}}, wake_req_out, state_q};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_sus_decode: assert property (!sus_in.s5_n |=> state_q == SWE_S5)
    else $error("S5 pin did not give S5 state");
  a_sus_s3_decode: assert property (
    sus_in.s5_n && sus_in.s4_n && !sus_in.s3_n |=> state_q == SWE_S3)
    else $error("low S3 pin did not give S3 state");
  a_always_wake: assert property (
    asleep && act[SRC_PWRBTN] |=> latch_q[SRC_PWRBTN] ##1 wake_req_out)
    else $error("power button did not raise a wake request");
  a_gen_wake_s3: assert property (
    state_q == SWE_S3 && act[SRC_GEN_WAKE] |=> latch_q[SRC_GEN_WAKE])
    else $error("general wake missed in S3");
  a_gen_no_deep: assert property (
    (state_q == SWE_S4 || state_q == SWE_S5) && !latch_q[SRC_GEN_WAKE]
    |=> !latch_q[SRC_GEN_WAKE])
    else $error("general wake latched in S4 or S5");
  a_pme_gated: assert property (
    !ctrl_q[CTRL_PME_EN] && !ctrl_q[CTRL_PME_CAP] && !latch_q[SRC_PME]
    |=> !latch_q[SRC_PME])
    else $error("PME latched while disabled");
  a_rtc_s5_only: assert property (
    (state_q != SWE_S5 || !ctrl_q[CTRL_RTC_EN]) && !latch_q[SRC_RTC]
    |=> !latch_q[SRC_RTC])
    else $error("RTC alarm latched outside enabled S5");
  a_usb_gated: assert property (
    (!ctrl_q[CTRL_USB_EN] || state_q == SWE_S5) && !latch_q[SRC_USB]
    |=> !latch_q[SRC_USB])
    else $error("USB wake latched while not permitted");
  a_lan_gated: assert property (
    !ctrl_q[CTRL_LAN_EN] && !latch_q[SRC_LAN] |=> !latch_q[SRC_LAN])
    else $error("network wake latched while not configured");
  a_strap_drive: assert property (
    capability_strap_out == '0 && capability_strap_oe_n_out == ~STRAP_TIED_GND)
    else $error("capability strap not at its pinout code");
  a_clear_on_work: assert property (
    state_q == SWE_WORK |=> latch_q == '0 ##1 !wake_req_out)
    else $error("wake latches not cleared in working state");
  a_irq_follow: assert property (
    (status_q & mask_q) != '0 |=> irq_out)
    else $error("unmasked status did not raise interrupt");

  // Remaining decode cases, so a wrong priority order cannot hide
  a_sus_s4_decode: assert property (
    sus_in.s5_n && !sus_in.s4_n
    |=> state_q == SWE_S4)
    else $error("low S4 pin did not give S4 state");
  a_sus_work_decode: assert property (
    sus_in.s5_n && sus_in.s4_n && sus_in.s3_n
    |=> state_q == SWE_WORK)
    else $error("released suspend pins did not give working state");

  // Always-on sources must reach their latch one cycle after being seen asleep
  a_smb_wake: assert property (
    asleep && act[SRC_SMBALERT]
    |=> latch_q[SRC_SMBALERT])
    else $error("SMB alert did not latch while asleep");
  a_pcie_wake: assert property (
    asleep && act[SRC_PCIE_WAKE]
    |=> latch_q[SRC_PCIE_WAKE])
    else $error("PCIe wake did not latch while asleep");
  a_wdt_wake: assert property (
    asleep && act[SRC_WDT_PWRBTN]
    |=> latch_q[SRC_WDT_PWRBTN])
    else $error("watchdog button did not latch while asleep");

  // Gated sources must still wake once their enable is present
  a_pme_wake: assert property (
    asleep && (ctrl_q[CTRL_PME_EN] || ctrl_q[CTRL_PME_CAP]) && act[SRC_PME]
    |=> latch_q[SRC_PME])
    else $error("enabled PME did not latch");
  a_rtc_wake: assert property (
    state_q == SWE_S5 && ctrl_q[CTRL_RTC_EN] && act[SRC_RTC]
    |=> latch_q[SRC_RTC])
    else $error("enabled RTC alarm did not latch in S5");
  a_usb_wake: assert property (
    (state_q == SWE_S3 || state_q == SWE_S4) && ctrl_q[CTRL_USB_EN] && act[SRC_USB]
    |=> latch_q[SRC_USB])
    else $error("enabled USB wake did not latch in S3 or S4");
  a_lan_wake: assert property (
    asleep && ctrl_q[CTRL_LAN_EN] && act[SRC_LAN]
    |=> latch_q[SRC_LAN])
    else $error("configured network wake did not latch");

  // Standby power for USB follows S3 exactly, one cycle late
  a_usb_standby: assert property (
    state_q == SWE_S3
    |=> usb_sby_pwr_out)
    else $error("USB standby power missing in S3");
  a_usb_no_standby: assert property (
    state_q != SWE_S3
    |=> !usb_sby_pwr_out)
    else $error("USB standby power held outside S3");

  // Request and status bookkeeping
  a_wake_req_drop: assert property (
    latch_q == '0
    |=> !wake_req_out)
    else $error("wake request held with no latch set");
  a_status_record: assert property (
    (latch_set & ~latch_q) != '0
    |=> status_q != '0)
    else $error("new wake latch not recorded in status");
  a_irq_low: assert property (
    (status_q & mask_q) == '0
    |=> !irq_out)
    else $error("interrupt raised with no unmasked status");
  a_rdata_idle: assert property (
    !bus_in.re
    |=> rdata_out == '0)
    else $error("read data not zero outside its read cycle");

  c_s3_button: cover property (state_q == SWE_S3 && act[SRC_PWRBTN] ##2 wake_req_out);
  c_s5_rtc: cover property (state_q == SWE_S5 && latch_set[SRC_RTC]);
  c_s4_usb: cover property (state_q == SWE_S4 && latch_set[SRC_USB]);
  c_irq_clear: cover property (irq_out && wr_status ##2 !irq_out);
  c_s3_gen_wake: cover property (state_q == SWE_S3 && latch_set[SRC_GEN_WAKE]);
endmodule : swe_wake_logic

// ### swe_carrier_model.sv
// Carrier board model: wake source pins, sleep sequencing and strap decode.
// Assumes the bench requests sources active high and commands sleep states.
`timescale 1ns/1ns
module swe_carrier_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire swe_pkg::swe_state_e cmd_in,
  input wire logic [swe_pkg::N_SRC-1:0] src_in,
  input wire logic wake_req_in,
  input wire logic [swe_pkg::STRAP_W-1:0] strap_in,
  input wire logic [swe_pkg::STRAP_W-1:0] strap_oe_n_in,
  output swe_pkg::swe_sus_s sus_out,
  output swe_pkg::swe_wake_s wake_out,
  output logic [swe_pkg::STRAP_W-1:0] pinout_out
);
  import swe_pkg::*;
  swe_state_e st_q;
  // Power sequencing returns to work as soon as the module asks for it
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) st_q <= SWE_WORK;
    else if (go_in) st_q <= cmd_in;
    else if (wake_req_in) st_q <= SWE_WORK;
  end
  // Deeper states also hold the shallower pins low
  assign sus_out.s3_n = (st_q == SWE_WORK);
  assign sus_out.s4_n = !(st_q == SWE_S4 || st_q == SWE_S5);
  assign sus_out.s5_n = (st_q != SWE_S5);
  assign wake_out.pwrbtn_n = ~src_in[SRC_PWRBTN];
  assign wake_out.smbalert_n = ~src_in[SRC_SMBALERT];
  assign wake_out.pcie_wake_n = ~src_in[SRC_PCIE_WAKE];
  assign wake_out.wdt_pwrbtn = src_in[SRC_WDT_PWRBTN];
  assign wake_out.gen_wake_n = ~src_in[SRC_GEN_WAKE];
  assign wake_out.pme_n = ~src_in[SRC_PME];
  assign wake_out.rtc_alarm = src_in[SRC_RTC];
  assign wake_out.usb_wake = src_in[SRC_USB];
  assign wake_out.lan_wake = src_in[SRC_LAN];
  // Carrier pull-up decode: an open strap gives a zero on pinout_out, a grounded one a one
  assign pinout_out = ~(strap_oe_n_in | strap_in);
endmodule : swe_carrier_model

// ### swe_tb.sv
// Self-checking bench for the wake event logic with a carrier model.
// Assumes one 100 MHz clock and the register map of the package.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
  import swe_pkg::*;
  localparam logic [STRAP_W-1:0] TIED = 3'h5;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic go = 1'h0;
  logic wake_req, irq, usb_sby;
  swe_state_e cmd = SWE_WORK;
  logic [N_SRC-1:0] src = '0;
  swe_sus_s sus;
  swe_wake_s wake;
  swe_bus_s bus = '0;
  logic [DATA_W-1:0] rdata, rd;
  logic [STRAP_W-1:0] strap, strap_oe_n, pinout;
  int failures = 0;
  int samples_checked = 0;
  swe_wake_logic #(.STRAP_TIED_GND(TIED)) DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .sus_in(sus), .wake_in(wake), .bus_in(bus), .rdata_out(rdata), .wake_req_out(wake_req),
    .irq_out(irq), .usb_sby_pwr_out(usb_sby), .capability_strap_out(strap),
    .capability_strap_oe_n_out(strap_oe_n));
  swe_carrier_model carrier (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .go_in(go),
    .cmd_in(cmd), .src_in(src), .wake_req_in(wake_req), .strap_in(strap),
    .strap_oe_n_in(strap_oe_n), .sus_out(sus), .wake_out(wake), .pinout_out(pinout));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic complete_run();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Each bus task ends in the time step of a rising edge; the last two calls in t_irq start 1 ns after one
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'h1;
    @(posedge clk_sys_in);
    bus.we <= 1'h0;
    @(posedge clk_sys_in);
  endtask : bus_wr
  task automatic bus_rd(input logic [ADDR_W-1:0] a);
    bus.addr <= a;
    bus.re <= 1'h1;
    @(posedge clk_sys_in);
    bus.re <= 1'h0;
    #1 rd = rdata;
    @(posedge clk_sys_in);
  endtask : bus_rd
  task automatic sleep(input swe_state_e s);
    go <= 1'h1;
    cmd <= s;
    @(posedge clk_sys_in);
    go <= 1'h0;
    repeat (2) @(posedge clk_sys_in);
  endtask : sleep
  function automatic logic permit(swe_state_e st, int k, logic [CTRL_W-1:0] c);
    case (k)
      SRC_GEN_WAKE: return st == SWE_S3;
      SRC_PME: return c[CTRL_PME_EN] | c[CTRL_PME_CAP];
      SRC_RTC: return st == SWE_S5 && c[CTRL_RTC_EN];
      SRC_USB: return st != SWE_S5 && c[CTRL_USB_EN];
      SRC_LAN: return c[CTRL_LAN_EN];
      default: return 1'h1;
    endcase
  endfunction : permit
  task automatic t_reset_regs();
    logic [ADDR_W-1:0] a;
    for (int i = 0; i < 6; i++) begin
      // The last address is unmapped and must read back zero
      a = (i == 5) ? 8'h20 : ADDR_W'(4 * i);
      bus_rd(a);
      `CHK(rd, 32'h0)
    end
    `CHK(strap, 3'h0)
    `CHK(pinout, TIED)
  endtask : t_reset_regs
  task automatic run_one(input swe_state_e st, input int k, input logic [CTRL_W-1:0] c);
    logic e;
    e = permit(st, k, c);
    bus_wr(ADDR_CTRL, DATA_W'(c));
    sleep(st);
    bus_rd(ADDR_STATE);
    `CHK(rd, DATA_W'(st))
    `CHK(usb_sby, 1'(st == SWE_S3))
    src <= N_SRC'(1) << k;
    @(posedge clk_sys_in);
    src <= '0;
    repeat (2) @(posedge clk_sys_in);
    #1 `CHK(wake_req, e)
    @(posedge clk_sys_in);
    sleep(SWE_WORK);
    repeat (3) @(posedge clk_sys_in);
    `CHK(wake_req, 1'h0)
    bus_rd(ADDR_LATCH);
    `CHK(rd, 32'h0)
    bus_rd(ADDR_STATUS);
    `CHK(rd, DATA_W'(e) << k)
    bus_wr(ADDR_STATUS, 32'h1FF);
    bus_rd(ADDR_STATUS);
    `CHK(rd, 32'h0)
  endtask : run_one
  task automatic t_sources();
    logic [CTRL_W-1:0] ctl [3] = '{5'h00, 5'h1F, 5'h02};
    for (int c = 0; c < 3; c++)
      for (int s = 1; s < 4; s++)
        for (int k = 0; k < N_SRC; k++) run_one(swe_state_e'(s), k, ctl[c]);
  endtask : t_sources
  task automatic t_irq();
    bus_wr(ADDR_MASK, 32'h1FF);
    sleep(SWE_S5);
    src <= N_SRC'(1) << SRC_WDT_PWRBTN;
    @(posedge clk_sys_in);
    src <= '0;
    repeat (3) @(posedge clk_sys_in);
    `CHK(irq, 1'h1)
    bus_wr(ADDR_MASK, 32'h0);
    // The interrupt flop updates at the edge the task returns on
    #1 `CHK(irq, 1'h0)
    bus_wr(ADDR_MASK, 32'h8);
    #1 `CHK(irq, 1'h1)
    bus_wr(ADDR_STATUS, 32'h8);
    @(posedge clk_sys_in);
    `CHK(irq, 1'h0)
  endtask : t_irq
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    @(posedge clk_sys_in);
    t_reset_regs();
    t_sources();
    t_irq();
    complete_run();
  end
  // Runs take about 2000 cycles; the limit leaves ample margin
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule : tb
